// file: bench/edpc_ctrl_asserts.sv
// Purpose: port checks for edpc_ctrl
// Assumes: bound to edpc_ctrl
// Notes: register state seen through write echoes and read data
`timescale 1ns/1ps
`default_nettype none
`include "edpc_params.svh"
module edpc_ctrl_asserts
  import edpc_pkg::*;
(
  // clock, reset, register port
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_index_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_ack_o,
  // watched outputs and their causes
  input wire logic cursor_blink_en_o,
  input wire logic font_fast_page_o,
  input wire logic [16:0] start_addr_hi_o,
  input wire logic [15:0] start_addr_lo_i,
  input wire logic panel_timing_scan_i,
  input wire logic [1:0] panel_timing_tft_i,
  input wire edpc_class_t panel_class_o,
  input wire logic dual_scan_o,
  input wire logic [4:0] tft_width_o,
  input wire logic [16:0] character_counter_address_i,
  input wire logic [16:0] refresh_addr_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ack edge sees the taken request one edge back
  a_wr_blink_echo: assert property (reg_ack_o && $past(reg_wr_i)
    && $past(reg_index_i) == `EDPC_IDX_EXT_DISP |-> cursor_blink_en_o == !$past(reg_wdata_i[7]))
    else $error("blink enable does not follow written bit");
  a_wr_fast_echo: assert property (reg_ack_o && $past(reg_wr_i)
    && $past(reg_index_i) == `EDPC_IDX_EXT_DISP |-> font_fast_page_o == $past(reg_wdata_i[6]))
    else $error("fast-page output does not follow written bit");
  a_rd_reserved_zero: assert property (reg_ack_o && $past(reg_rd_i) && !$past(reg_wr_i)
    && $past(reg_index_i) == `EDPC_IDX_EXT_DISP |-> (reg_rdata_o & ~`EDPC_EXT_DISP_MASK) == 8'h00)
    else $error("reserved bits read nonzero");
  a_start_low_pass: assert property (start_addr_hi_o[15:0] == start_addr_lo_i)
    else $error("start address low bits altered");
  a_wr_start_echo: assert property (reg_ack_o && $past(reg_wr_i)
    && $past(reg_index_i) == `EDPC_IDX_EXT_DISP
    |-> start_addr_hi_o[16] == $past(reg_wdata_i[0]))
    else $error("start bit 16 does not follow written bit");
  a_mono_scan_sel: assert property (panel_class_o == PANEL_MONO
    |-> dual_scan_o == !panel_timing_scan_i)
    else $error("mono scan select wrong");
  a_other_scan_off: assert property (panel_class_o inside {PANEL_MONO4, PANEL_TFT}
    |-> !dual_scan_o)
    else $error("dual scan set for wrong class");
  a_tft_width_map: assert property (panel_class_o == PANEL_TFT |-> tft_width_o ==
    (panel_timing_tft_i == 2'h0 ? 5'h09 : panel_timing_tft_i == 2'h1 ? 5'h0c : 5'h12))
    else $error("tft width wrong");
  a_refresh_low_pass: assert property (refresh_addr_o[15:0] ==
    character_counter_address_i[15:0])
    else $error("refresh address low bits altered");
endmodule : edpc_ctrl_asserts
bind edpc_ctrl edpc_ctrl_asserts u_chk (.*);
`default_nettype wire

// file: bench/extended_display_panel_controls_bench.sv
// Purpose: directed bench for edpc_ctrl
// Assumes: one request per two cycles
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module extended_display_panel_controls_bench
  import edpc_pkg::*;
;
  logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, reg_ack_o, vt_wr_i, dual_scan_o, suspend_pd_o;
  logic [7:0] reg_index_i, reg_wdata_i, reg_rdata_o, vt_wdata_i, vt_timing_o, vt_shadow_o;
  logic timing_blank_i, display_enable_i, vblank_de_i, vblank_tft_i, cursor_blink_en_o;
  logic font_fast_page_o, dac_blank_o, panel_display_enable_out_o, chain4_i, dword_i;
  logic panel_timing_scan_i, sequencer_panel_extension_i, line_raw_i, frame_raw_i;
  logic panel_line_clock_o, panel_frame_start_o, four_chips_i;
  logic [16:0] start_addr_hi_o, host_bus_address_i, character_counter_address_i, refresh_addr_o;
  logic [15:0] start_addr_lo_i;
  logic [1:0] panel_timing_tft_i, host_dram_a01_o, refresh_dram_a01_o;
  logic [4:0] tft_width_o;
  logic [6:0] offset_i;
  logic [17:0] host_linear_i;
  logic [18:0] host_memory_address_o;
  edpc_class_t panel_class_o;
  int failures, compares;
  edpc_ctrl dut (.*);
  initial
  begin
    sys_clk_i = 0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task chk(input logic [18:0] got, input logic [18:0] exp);
    compares++;
    if (got !== exp)
      failures++;
    if (got !== exp)
      $display("[ERR] %0t got %h want %h", $time, got, exp);
  endtask : chk
  // request held through the rising edge that samples ack, released at the falling edge after
  task acc(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(negedge sys_clk_i);
    reg_index_i = i;
    reg_wdata_i = d;
    reg_wr_i = w;
    reg_rd_i = !w;
    n = 0;
    do
    begin
      @(negedge sys_clk_i);
      n++;
    end
    while (reg_ack_o !== 1'b1 && n < 8);
    chk(reg_ack_o, 1);
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reg_wr_i = 0;
    reg_rd_i = 0;
  endtask : acc
  task close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  initial
  begin
    #20000;
    failures++;
    close_out();
  end
  initial
  begin
    {reg_wr_i, reg_rd_i, vt_wr_i, timing_blank_i, display_enable_i, vblank_de_i} = 6'h00;
    {vblank_tft_i, panel_timing_scan_i, sequencer_panel_extension_i, line_raw_i} = 4'h0;
    {frame_raw_i, chain4_i, dword_i, four_chips_i, panel_timing_tft_i} = 6'h00;
    {reg_index_i, reg_wdata_i, vt_wdata_i} = 24'h000000;
    start_addr_lo_i = 16'h1234;
    host_bus_address_i = 17'h1fabc;
    offset_i = 7'h01;
    host_linear_i = 18'h2c000;
    character_counter_address_i = 17'h1c000;
    rst_i = 1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 0;
    acc(0, 8'h1b, 0);
    chk(reg_rdata_o, 0);
    acc(0, 8'h1c, 0);
    chk(reg_rdata_o, 0);
    chk(cursor_blink_en_o, 1);
    chk(suspend_pd_o, 0);
    chk(panel_class_o, 0);
    $display("reset test done");
    acc(1, 8'h1b, 8'hff);
    vblank_tft_i = 1;
    acc(0, 8'h1b, 0);
    chk(reg_rdata_o, 8'he7);
    chk(cursor_blink_en_o, 0);
    chk(font_fast_page_o, 1);
    chk(start_addr_hi_o, 17'h11234);
    chk(dac_blank_o, 1);
    chk(panel_display_enable_out_o, 1);
    display_enable_i = 1;
    repeat (2) @(negedge sys_clk_i);
    chk(dac_blank_o, 0);
    acc(1, 8'h1b, 8'h00);
    repeat (2) @(negedge sys_clk_i);
    chk(dac_blank_o, 0);
    chk(panel_display_enable_out_o, 0);
    chk(font_fast_page_o, 0);
    chk(start_addr_hi_o, 17'h01234);
    timing_blank_i = 1;
    repeat (2) @(negedge sys_clk_i);
    chk(dac_blank_o, 1);
    $display("display test done");
    for (int c = 0; c < 4; c++)
    begin
      acc(1, 8'h1c, {c[1:0], 6'h00});
      panel_timing_tft_i = 2'h3;
      panel_timing_scan_i = c[0];
      sequencer_panel_extension_i = !c[0];
      #1;
      chk(panel_class_o, c[1:0]);
      chk(dual_scan_o, !c[0]);
      chk(tft_width_o, c == 3 ? 5'h12 : 5'h00);
      @(negedge sys_clk_i);
      panel_timing_scan_i = !c[0];
      sequencer_panel_extension_i = c[0];
      #1;
      chk(dual_scan_o, 0);
    end
    @(negedge sys_clk_i);
    panel_timing_tft_i = 2'h0;
    #1;
    chk(tft_width_o, 5'h09);
    @(negedge sys_clk_i);
    panel_timing_tft_i = 2'h1;
    #1;
    chk(tft_width_o, 5'h0c);
    @(negedge sys_clk_i);
    panel_timing_tft_i = 2'h2;
    #1;
    chk(tft_width_o, 5'h12);
    @(negedge sys_clk_i);
    vt_wr_i = 1;
    vt_wdata_i = 8'h33;
    @(negedge sys_clk_i);
    vt_wr_i = 0;
    chk(vt_timing_o, 8'h33);
    chk(vt_shadow_o, 8'h33);
    acc(1, 8'h1c, 8'hff);
    vt_wr_i = 1;
    vt_wdata_i = 8'h5a;
    @(negedge sys_clk_i);
    vt_wr_i = 0;
    acc(0, 8'h1c, 0);
    chk(reg_rdata_o, 8'hcf);
    chk(suspend_pd_o, 1);
    chk({panel_line_clock_o, panel_frame_start_o}, 2'h3);
    chk(vt_timing_o, 8'h33);
    chk(vt_shadow_o, 8'h5a);
    {line_raw_i, frame_raw_i} = 2'h2;
    repeat (2) @(negedge sys_clk_i);
    chk({panel_line_clock_o, panel_frame_start_o}, 2'h1);
    acc(1, 8'h20, 8'hff);
    acc(0, 8'h20, 0);
    chk(reg_rdata_o, 0);
    $display("panel test done");
    acc(1, 8'h1b, 8'h02);
    {chain4_i, dword_i, four_chips_i} = 3'h7;
    #1;
    chk(host_memory_address_o, 19'h20abc);
    chk(host_dram_a01_o, 2'h2);
    chk(refresh_dram_a01_o, 2'h3);
    chk(refresh_addr_o, 17'h1c000);
    @(negedge sys_clk_i);
    four_chips_i = 0;
    #1;
    chk(refresh_addr_o, 17'h0c000);
    acc(1, 8'h1b, 8'h00);
    four_chips_i = 1;
    #1;
    chk(host_memory_address_o, 19'h0fabc);
    chk(host_dram_a01_o, 2'h3);
    chk(refresh_dram_a01_o, 2'h0);
    chk(refresh_addr_o, 17'h0c000);
    $display("address test done");
    close_out();
  end
endmodule : extended_display_panel_controls_bench
`default_nettype wire

// file: hdl/edpc_addr_map.sv
// Purpose: display-memory address forming for extended wrap
// Assumes: offset register value selected outside
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module edpc_addr_map
  import edpc_pkg::*;
(
  // control
  input wire logic ext_wrap_i,
  input wire logic chain4_i,
  input wire logic dword_i,
  input wire logic four_chips_i,
  // addresses
  input wire logic [16:0] host_bus_address_i,
  input wire logic [6:0] offset_i,
  input wire logic [17:0] host_linear_i,
  input wire logic [16:0] character_counter_address_i,
  output logic [18:0] host_memory_address_o,
  output logic [1:0] host_dram_a01_o,
  output logic [1:0] refresh_dram_a01_o,
  output logic [16:0] refresh_addr_o
);
  wire logic [6:0] sum_hi;
  assign sum_hi = 7'({2'h0, host_bus_address_i[16:12]} + offset_i);
  assign host_memory_address_o = ext_wrap_i ? {sum_hi, host_bus_address_i[11:0]} :
    {3'h0, host_bus_address_i[15:0]};
  assign host_dram_a01_o = (ext_wrap_i && chain4_i) ? host_linear_i[17:16] :
    host_linear_i[15:14];
  assign refresh_dram_a01_o = (ext_wrap_i && dword_i) ?
    character_counter_address_i[15:14] : character_counter_address_i[13:12];
  assign refresh_addr_o = {ext_wrap_i & four_chips_i & character_counter_address_i[16],
    character_counter_address_i[15:0]};
endmodule : edpc_addr_map
`default_nettype wire

// file: hdl/edpc_ctrl.sv
// Purpose: extended display and flat panel control registers
// Assumes: indexed register port, synchronous strobes
// Notes: vertical timing held under protect, shadow keeps taking writes
`timescale 1ns/1ps
`default_nettype none
`include "edpc_params.svh"
module edpc_ctrl
  import edpc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // indexed register port
  input wire logic [7:0] reg_index_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  // vertical timing writes (protected set)
  input wire logic vt_wr_i,
  input wire logic [7:0] vt_wdata_i,
  output logic [7:0] vt_timing_o,
  output logic [7:0] vt_shadow_o,
  // display controls
  input wire logic timing_blank_i,
  input wire logic display_enable_i,
  input wire logic vblank_de_i,
  input wire logic vblank_tft_i,
  output logic cursor_blink_en_o,
  output logic font_fast_page_o,
  output logic dac_blank_o,
  output logic panel_display_enable_out_o,
  output logic [16:0] start_addr_hi_o,
  input wire logic [15:0] start_addr_lo_i,
  // panel selection
  input wire logic panel_timing_scan_i,
  input wire logic sequencer_panel_extension_i,
  input wire logic [1:0] panel_timing_tft_i,
  output edpc_class_t panel_class_o,
  output logic dual_scan_o,
  output logic [4:0] tft_width_o,
  output logic suspend_pd_o,
  // panel strobes
  input wire logic line_raw_i,
  input wire logic frame_raw_i,
  output logic panel_line_clock_o,
  output logic panel_frame_start_o,
  // memory addressing
  input wire logic chain4_i,
  input wire logic dword_i,
  input wire logic four_chips_i,
  input wire logic [16:0] host_bus_address_i,
  input wire logic [6:0] offset_i,
  input wire logic [17:0] host_linear_i,
  input wire logic [16:0] character_counter_address_i,
  output logic [18:0] host_memory_address_o,
  output logic [1:0] host_dram_a01_o,
  output logic [1:0] refresh_dram_a01_o,
  output logic [16:0] refresh_addr_o
);
  edpc_state_t state_q;
  edpc_state_t state_d;
  logic [7:0] disp_q;
  logic [7:0] panel_q;
  logic [7:0] vt_q;
  logic [7:0] vt_shadow_q;
  logic [7:0] rdata_q;
  logic dpe_q;
  logic dac_q;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction : hit

  wire logic sel_disp;
  wire logic sel_panel;
  wire edpc_disp_t disp;
  wire edpc_panel_t panel;
  wire logic [7:0] rd_mux;
  assign sel_disp = hit(reg_index_i, `EDPC_IDX_EXT_DISP);
  assign sel_panel = hit(reg_index_i, `EDPC_IDX_FP_IF);
  assign disp = '{no_blink: disp_q[`EDPC_BIT_NO_BLINK], fast_page: disp_q[`EDPC_BIT_FAST_PAGE],
    blank_de: disp_q[`EDPC_BIT_BLANK_DE], vblank: disp_q[`EDPC_BIT_VBLANK],
    ext_wrap: disp_q[`EDPC_BIT_EXT_WRAP], start16: disp_q[`EDPC_BIT_START16]};
  assign panel = '{panel_class: edpc_class_t'(panel_q[`EDPC_BIT_CLASS_HI:`EDPC_BIT_CLASS_LO]),
    protect: panel_q[`EDPC_BIT_PROTECT], suspend: panel_q[`EDPC_BIT_SUSPEND],
    inv_line: panel_q[`EDPC_BIT_INV_LINE], inv_frame: panel_q[`EDPC_BIT_INV_FRAME]};
  // unmapped index reads zero
  assign rd_mux = sel_disp ? disp_q : (sel_panel ? panel_q : 8'h00);

  always_comb
  begin
    case (state_q)
      ST_IDLE: state_d = reg_wr_i ? ST_WRITE : (reg_rd_i ? ST_READ : ST_IDLE);
      ST_WRITE: state_d = ST_IDLE;
      ST_READ: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      disp_q <= `EDPC_RESET_VAL;
      panel_q <= `EDPC_RESET_VAL;
      rdata_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE && reg_wr_i && sel_disp)
        disp_q <= reg_wdata_i & `EDPC_EXT_DISP_MASK;
      if (state_q == ST_IDLE && reg_wr_i && sel_panel)
        panel_q <= reg_wdata_i & `EDPC_FP_IF_MASK;
      if (state_q == ST_IDLE && reg_rd_i && !reg_wr_i)
        rdata_q <= rd_mux;
    end
  end

  // protected copy freezes; shadow keeps taking writes for readback
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vt_q <= 8'h00;
      vt_shadow_q <= 8'h00;
    end
    else if (vt_wr_i)
    begin
      vt_shadow_q <= vt_wdata_i;
      if (!panel.protect)
        vt_q <= vt_wdata_i;
    end
  end

  // blank and panel enable registered so they stay glitch-free to the pins
  wire logic dpe_d;
  assign dpe_d = disp.vblank ? vblank_tft_i : vblank_de_i;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dac_q <= 1'b0;
      dpe_q <= 1'b0;
    end
    else
    begin
      dac_q <= disp.blank_de ? !display_enable_i : timing_blank_i;
      dpe_q <= dpe_d;
    end
  end

  assign reg_ack_o = (state_q != ST_IDLE);
  assign reg_rdata_o = rdata_q;
  assign vt_timing_o = vt_q;
  assign vt_shadow_o = vt_shadow_q;
  assign cursor_blink_en_o = !disp.no_blink;
  assign font_fast_page_o = disp.fast_page;
  assign dac_blank_o = dac_q;
  assign panel_display_enable_out_o = dpe_q;
  assign start_addr_hi_o = {disp.start16, start_addr_lo_i};
  assign panel_class_o = panel.panel_class;
  assign suspend_pd_o = panel.suspend;

  // scan mode per class
  assign dual_scan_o = (panel.panel_class == PANEL_MONO) ? !panel_timing_scan_i :
    (panel.panel_class == PANEL_STN) ? sequencer_panel_extension_i : 1'b0;
  // colour width only meaningful for the tft class
  assign tft_width_o = (panel.panel_class != PANEL_TFT) ? 5'h00 :
    (panel_timing_tft_i == 2'h0) ? 5'h09 : (panel_timing_tft_i == 2'h1) ? 5'h0c : 5'h12;

  edpc_panel_out u_panel_out (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .panel_i(panel),
    .line_raw_i(line_raw_i),
    .frame_raw_i(frame_raw_i),
    .panel_line_clock_o(panel_line_clock_o),
    .panel_frame_start_o(panel_frame_start_o)
  );

  edpc_addr_map u_addr_map (
    .ext_wrap_i(disp.ext_wrap),
    .chain4_i(chain4_i),
    .dword_i(dword_i),
    .four_chips_i(four_chips_i),
    .host_bus_address_i(host_bus_address_i),
    .offset_i(offset_i),
    .host_linear_i(host_linear_i),
    .character_counter_address_i(character_counter_address_i),
    .host_memory_address_o(host_memory_address_o),
    .host_dram_a01_o(host_dram_a01_o),
    .refresh_dram_a01_o(refresh_dram_a01_o),
    .refresh_addr_o(refresh_addr_o)
  );
endmodule : edpc_ctrl
`default_nettype wire

// file: hdl/edpc_panel_out.sv
// Purpose: panel line and frame signal polarity
// Assumes: raw panel timing from elsewhere
// Notes: outputs registered
`timescale 1ns/1ps
`default_nettype none
module edpc_panel_out
  import edpc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire edpc_panel_t panel_i,
  input wire logic line_raw_i,
  input wire logic frame_raw_i,
  output logic panel_line_clock_o,
  output logic panel_frame_start_o
);
  logic line_q;
  logic frame_q;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      line_q <= 1'b0;
      frame_q <= 1'b0;
    end
    else
    begin
      line_q <= line_raw_i ^ panel_i.inv_line;
      frame_q <= frame_raw_i ^ panel_i.inv_frame;
    end
  end
  assign panel_line_clock_o = line_q;
  assign panel_frame_start_o = frame_q;
endmodule : edpc_panel_out
`default_nettype wire

// file: inc/edpc_params.svh
// Purpose: offsets, field positions, reset values for the display/panel control pair
// Assumes: 8-bit indexed register port
// Notes: definitions only
`ifndef EDPC_PARAMS_SVH
`define EDPC_PARAMS_SVH
`define EDPC_IDX_EXT_DISP 8'h1b
`define EDPC_IDX_FP_IF 8'h1c
`define EDPC_EXT_DISP_MASK 8'he7
`define EDPC_FP_IF_MASK 8'hcf
`define EDPC_RESET_VAL 8'h00
`define EDPC_BIT_NO_BLINK 7
`define EDPC_BIT_FAST_PAGE 6
`define EDPC_BIT_BLANK_DE 5
`define EDPC_BIT_VBLANK 2
`define EDPC_BIT_EXT_WRAP 1
`define EDPC_BIT_START16 0
`define EDPC_BIT_CLASS_HI 7
`define EDPC_BIT_CLASS_LO 6
`define EDPC_BIT_PROTECT 3
`define EDPC_BIT_SUSPEND 2
`define EDPC_BIT_INV_LINE 1
`define EDPC_BIT_INV_FRAME 0
`endif

// file: inc/edpc_pkg.sv
// Purpose: types shared by the display/panel control files
// Assumes: nothing
// Notes: one-hot access state
package edpc_pkg;
  typedef enum logic [1:0] {
    PANEL_MONO = 2'h0,
    PANEL_MONO4 = 2'h1,
    PANEL_STN = 2'h2,
    PANEL_TFT = 2'h3
  } edpc_class_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WRITE = 3'h2,
    ST_READ = 3'h4
  } edpc_state_t;
  typedef struct packed {
    logic no_blink;
    logic fast_page;
    logic blank_de;
    logic vblank;
    logic ext_wrap;
    logic start16;
  } edpc_disp_t;
  typedef struct packed {
    edpc_class_t panel_class;
    logic protect;
    logic suspend;
    logic inv_line;
    logic inv_frame;
  } edpc_panel_t;
endpackage : edpc_pkg
